// ==== ifdm_core.v ====
// Instruction fetch sequencing and banked data memory mapping
`timescale 1ns/1ps
`default_nettype none
`include "ifdm_regs.vh"
module ifdm_core #(
    parameter USER_BYTES = 3904
) (
    input wire clk,
    input wire srst,
    input wire step_en,
    input wire [15:0] fetch_word,
    input wire skip_flush,
    input wire take_branch,
    input wire [10:0] branch_offset,
    input wire usb_enable,
    input wire [3:0] bank_pointer,
    input wire core_req,
    input wire core_we,
    input wire access_sel,
    input wire full_addr_en,
    input wire [11:0] core_full_addr,
    input wire [7:0] core_addr_low,
    input wire [7:0] core_wdata,
    input wire sie_req,
    input wire sie_we,
    input wire [11:0] sie_addr,
    input wire [7:0] sie_wdata,
    output reg [20:0] program_counter_ff,
    output reg [11:0] second_literal_ff,
    output reg second_valid_ff,
    output reg nop_exec_ff,
    output reg [7:0] core_rdata_ff,
    output reg core_rvalid_ff,
    output reg [7:0] sie_rdata_ff,
    output reg sie_rvalid_ff,
    output reg sie_grant_ff
);
    reg expect_second_ff;
    reg [19:0] jump_low_ff;
    reg jump_pend_ff;
    reg [20:0] nxt_pc;
    reg nxt_expect;
    wire [3:0] tag = fetch_word[15:12];
    wire is_second = (tag == `IFDM_SECOND_TAG);
    wire first_call = (fetch_word[15:9] == `IFDM_OP_CALL);
    wire first_jump = (fetch_word[15:8] == `IFDM_OP_JUMP);
    wire first_move = (tag == `IFDM_OP_MOVE);
    wire first_load = (fetch_word[15:8] == `IFDM_OP_LOAD);
    wire two_word = first_call | first_jump | first_move | first_load;
    wire [20:0] br_disp = {{9{branch_offset[10]}}, branch_offset, 1'b0};
    always @* begin
        nxt_pc = program_counter_ff + `IFDM_PC_STEP;
        nxt_expect = expect_second_ff;
        if (skip_flush || take_branch) begin
            nxt_expect = 1'b0;
        end else if (expect_second_ff) begin
            nxt_expect = 1'b0;
        end else begin
            nxt_expect = two_word & ~is_second;
        end
        if (take_branch) begin
            nxt_pc = program_counter_ff + br_disp;
        end else if (expect_second_ff && jump_pend_ff && !skip_flush) begin
            // Word target into bits 20:1, bit 0 forced low
            nxt_pc = {fetch_word[11:0], jump_low_ff[7:0], 1'b0};
        end
        nxt_pc[0] = 1'b0;
    end
    always @(posedge clk) begin
        if (srst) begin
            program_counter_ff <= `IFDM_PC_RST;
            expect_second_ff <= 1'b0;
            jump_low_ff <= 20'h00000;
            jump_pend_ff <= 1'b0;
            second_literal_ff <= 12'h000;
            second_valid_ff <= 1'b0;
            nop_exec_ff <= 1'b0;
        end else begin
            second_valid_ff <= 1'b0;
            nop_exec_ff <= 1'b0;
            if (step_en) begin
                program_counter_ff <= nxt_pc;
                expect_second_ff <= nxt_expect;
                if (expect_second_ff && !skip_flush && !take_branch) begin
                    second_literal_ff <= fetch_word[11:0];
                    second_valid_ff <= 1'b1;
                    jump_pend_ff <= 1'b0;
                end else if (is_second) begin
                    nop_exec_ff <= 1'b1;
                end else begin
                    jump_pend_ff <= first_call | first_jump;
                    jump_low_ff <= {12'h000, fetch_word[7:0]};
                end
            end
        end
    end
    // Data address formation
    reg [11:0] core_addr;
    always @* begin
        if (full_addr_en) begin
            core_addr = core_full_addr;
        end else if (!access_sel) begin
            // Low part to bank 0, high part to bank 15
            if (core_addr_low < `IFDM_FAST_SPLIT) begin
                core_addr = {4'h0, core_addr_low};
            end else begin
                core_addr = {`IFDM_BANK_HIGH, core_addr_low};
            end
        end else begin
            core_addr = {bank_pointer, core_addr_low};
        end
    end
    // No holes: bank 15 below the register area is user space, 12'hF00 up to base
    wire user_hit = (core_addr < USER_BYTES);
    wire core_impl = user_hit || (core_addr >= `IFDM_SFR_BASE);
    // Engine only gets the port while USB is on
    wire sie_go = usb_enable & sie_req;
    // Core keeps port A; engine has port B; same byte write goes to core first
    wire clash = sie_go & sie_we & core_req & core_we & (sie_addr == core_addr);
    reg sie_hold_ff;
    reg [11:0] sie_addr_h_ff;
    reg [7:0] sie_wdata_h_ff;
    wire b_act = sie_hold_ff | (sie_go & ~clash);
    wire [11:0] b_addr = sie_hold_ff ? sie_addr_h_ff : sie_addr;
    wire [7:0] b_wdata = sie_hold_ff ? sie_wdata_h_ff : sie_wdata;
    wire b_we = sie_hold_ff | (sie_go & sie_we & ~clash);
    wire [7:0] a_rdata;
    wire [7:0] b_rdata;
    reg core_rd_pend_ff;
    reg core_impl_ff;
    reg sie_rd_pend_ff;
    ifdm_dual_ram #(
        .AW(`IFDM_DADDR_W),
        .DEPTH(4096)
    ) u_ram (
        .clk(clk),
        .a_we(core_req & core_we & core_impl),
        .a_addr(core_addr),
        .a_wdata(core_wdata),
        .a_rdata(a_rdata),
        .b_we(b_we),
        .b_addr(b_addr),
        .b_wdata(b_wdata),
        .b_rdata(b_rdata)
    );
    always @(posedge clk) begin
        if (srst) begin
            sie_hold_ff <= 1'b0;
            sie_addr_h_ff <= 12'h000;
            sie_wdata_h_ff <= 8'h00;
            core_rd_pend_ff <= 1'b0;
            core_impl_ff <= 1'b0;
            sie_rd_pend_ff <= 1'b0;
            core_rdata_ff <= 8'h00;
            core_rvalid_ff <= 1'b0;
            sie_rdata_ff <= 8'h00;
            sie_rvalid_ff <= 1'b0;
            sie_grant_ff <= 1'b0;
        end else begin
            // Deferred engine write lands next cycle, after the core's
            sie_hold_ff <= clash;
            sie_addr_h_ff <= sie_addr;
            sie_wdata_h_ff <= sie_wdata;
            sie_grant_ff <= sie_go;
            core_rd_pend_ff <= core_req & ~core_we;
            core_impl_ff <= core_impl;
            sie_rd_pend_ff <= b_act & ~b_we;
            core_rvalid_ff <= core_rd_pend_ff;
            if (core_rd_pend_ff) begin
                core_rdata_ff <= core_impl_ff ? a_rdata : 8'h00;
            end
            sie_rvalid_ff <= sie_rd_pend_ff;
            if (sie_rd_pend_ff) begin
                sie_rdata_ff <= b_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// ==== ifdm_dual_ram.v ====
// Dual-access data RAM with two synchronous ports
`timescale 1ns/1ps
`default_nettype none
module ifdm_dual_ram #(
    parameter AW = 12,
    parameter DEPTH = 4096
) (
    input wire clk,
    input wire a_we,
    input wire [AW-1:0] a_addr,
    input wire [7:0] a_wdata,
    output reg [7:0] a_rdata,
    input wire b_we,
    input wire [AW-1:0] b_addr,
    input wire [7:0] b_wdata,
    output reg [7:0] b_rdata
);
    reg [7:0] mem [0:DEPTH-1];
    // Two true ports, so both agents reach every byte each cycle
    // One process owns the array; the core avoids same-byte writes in one cycle
    always @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule
`default_nettype wire

// ==== ifdm_regs.vh ====
// Constants for the instruction fetch and data map block
// Overview of operation
// - Instructions sit at even byte addresses
// - Program counter steps by two, bit zero
// - Absolute target loads counter bits 20:1
// - Branch offset doubled into byte displacement
// - Four two-word instructions, second word 1111
// - Second word literal feeds instruction in progress
// - Lone 1111 word executes as no-operation
// - Data memory addressed by 12 bits
// - Sixteen banks of 256 bytes each
// - All banks present, 3904 user bytes
// - Unimplemented data locations read as zero on core port
// - 256-byte fast-access bank, no bank pointer
// - Data memory is dual-access RAM
// - USB off: shared banks are ordinary registers
// - USB on: banks are shared buffer RAM
// - Fast bank: bank 0 low 96, bank 15 top 160
// - Access bit zero selects fast-access map
// - Bank pointer gives upper four address bits
`ifndef IFDM_REGS_VH
`define IFDM_REGS_VH
`define IFDM_PC_W 21
`define IFDM_PC_RST 21'h000000
`define IFDM_PC_STEP 21'h000002
`define IFDM_DADDR_W 12
`define IFDM_SECOND_TAG 4'hF
`define IFDM_OP_CALL 7'h76
`define IFDM_OP_JUMP 8'hEF
`define IFDM_OP_MOVE 4'hC
`define IFDM_OP_LOAD 8'hEE
`define IFDM_OP_BRA 5'h1A
`define IFDM_FAST_SPLIT 8'h60
`define IFDM_BANK_HIGH 4'hF
`define IFDM_SFR_BASE 12'hF40
`define IFDM_SFR_FAST 12'hF60
`endif

// ==== ifdm_sie_model.sv ====
// Serial engine side model making one-cycle requests
`timescale 1ns/1ps
`default_nettype none
module ifdm_sie_model (
    input wire logic clk,
    output logic req,
    output logic we,
    output logic [11:0] addr,
    output logic [7:0] wdata
);
    initial {req, we, addr, wdata} = '0;
    // Released lines show junk; we left alone
    task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        {req, we, addr, wdata} = {1'b1, w, a, d};
        @(negedge clk);
        {req, addr, wdata} = {1'b0, ~a, ~d};
        repeat (3) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ==== ifdm_sva.sv ====
// Checker for fetch stepping and engine grant
`timescale 1ns/1ps
`default_nettype none
module ifdm_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic step_en,
    input wire logic [15:0] fetch_word,
    input wire logic skip_flush,
    input wire logic take_branch,
    input wire logic usb_enable,
    input wire logic sie_req,
    input wire logic [20:0] program_counter_ff,
    input wire logic nop_exec_ff,
    input wire logic sie_grant_ff
);
    logic exp_ff;
    wire logic first = fetch_word[15:9] == 7'h76 || fetch_word[15:8] == 8'hEF ||
        fetch_word[15:12] == 4'hC || fetch_word[15:8] == 8'hEE;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    always_ff @(posedge clk) begin
        if (srst) exp_ff <= 1'b0;
        else if (step_en) exp_ff <= first && !skip_flush && !take_branch;
    end
    sequence f_s;
        step_en && fetch_word[15:12] == 4'hF && !skip_flush;
    endsequence
    pc_even_a: assert property (!program_counter_ff[0]) else $error("pc odd");
    pc_step_a: assert property (step_en && !skip_flush && !take_branch && !fetch_word[15]
        |=> program_counter_ff == $past(program_counter_ff) + 21'h000002) else $error("step");
    pc_hold_a: assert property (!step_en |=> $stable(program_counter_ff)) else $error("hold");
    pc_reset_a: assert property (disable iff (1'b0) srst |=> !program_counter_ff && !nop_exec_ff)
        else $error("reset");
    lone_nop_a: assert property (!exp_ff ##0 f_s |-> ##[1:2] nop_exec_ff) else $error("nop");
    pair_quiet_a: assert property (exp_ff ##0 f_s |=> !nop_exec_ff [*2]) else $error("pair");
    grant_a: assert property (sie_req && usb_enable |=> sie_grant_ff) else $error("grant");
    no_grant_a: assert property (sie_req && !usb_enable |=> !sie_grant_ff) else $error("off");
endmodule
bind ifdm_core ifdm_sva u_ifdm_sva (.*);
`default_nettype wire

// ==== ifdm_tb.sv ====
// Bench for fetch stepping, two-word handling and data map
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, srst, step_en, skip_flush, take_branch, usb_enable, core_req, core_we;
    logic access_sel, full_addr_en, sie_req, sie_we, second_valid_ff, nop_exec_ff;
    logic sie_grant_ff;
    logic [15:0] fetch_word;
    logic [10:0] branch_offset;
    logic [3:0] bank_pointer;
    logic [11:0] core_full_addr, sie_addr, second_literal_ff;
    logic [7:0] core_addr_low, core_wdata, sie_wdata, core_rdata_ff, sie_rdata_ff;
    logic [20:0] program_counter_ff, p, d;
    int bad_count, checks, nops, grants, n;
    ifdm_core u_ifdm_core (.*, .core_rvalid_ff(), .sie_rvalid_ff());
    ifdm_sie_model u_ifdm_sie_model (.clk, .req(sie_req), .we(sie_we), .addr(sie_addr),
        .wdata(sie_wdata));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        nops += nop_exec_ff;
        grants += sie_grant_ff;
    end
    task chk(input logic ok, input string m);
        checks++;
        if (!ok) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task stop_test;
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task stp(input logic [15:0] w, input logic f, b, input logic [10:0] o);
        @(negedge clk);
        {step_en, fetch_word, skip_flush, take_branch, branch_offset} = {1'b1, w, f, b, o};
        @(negedge clk);
        step_en = 0;
    endtask
    task cacc(input logic w, s, input logic [11:0] a, input logic [7:0] dw, e);
        @(negedge clk);
        {core_req, core_we, access_sel, core_full_addr, core_wdata} = {1'b1, w, s, a, dw};
        {bank_pointer, core_addr_low} = a;
        @(negedge clk);
        {core_req, core_wdata} = {1'b0, ~dw};
        repeat (2) @(negedge clk);
        if (!w) chk(core_rdata_ff === e, "read");
    endtask
    task t_fetch;
        stp(16'h0F55, 1'b0, 1'b0, 11'h000);
        chk(program_counter_ff === 21'h000002, "pc step");
        stp(16'hEF03, 1'b0, 1'b0, 11'h000);
        stp(16'hF000, 1'b0, 1'b0, 11'h000);
        chk(program_counter_ff === 21'h000006, "jump");
        p = program_counter_ff;
        stp(16'h0000, 1'b0, 1'b1, 11'h000);
        d = program_counter_ff - p;
        p = program_counter_ff;
        stp(16'h0000, 1'b0, 1'b1, 11'h7FD);
        chk(program_counter_ff - p === d - 21'h000006, "branch");
        $display("fetch done");
    endtask
    task t_words;
        stp(16'hC123, 1'b0, 1'b0, 11'h000);
        stp(16'hF456, 1'b0, 1'b0, 11'h000);
        repeat (3) @(negedge clk);
        chk(second_literal_ff === 12'h456, "pair");
        n = nops;
        stp(16'hC123, 1'b1, 1'b0, 11'h000);
        stp(16'hF456, 1'b0, 1'b0, 11'h000);
        repeat (3) @(negedge clk);
        chk(nops === n + 1, "lone");
        $display("words done");
    endtask
    task t_data;
        cacc(1'b1, 1'b0, 12'h712, 8'hA5, 8'h00);
        cacc(1'b0, 1'b1, 12'h012, 8'h00, 8'hA5);
        cacc(1'b1, 1'b0, 12'h380, 8'h3C, 8'h00);
        cacc(1'b0, 1'b1, 12'hF80, 8'h00, 8'h3C);
        $display("data done");
    endtask
    task t_usb;
        n = grants;
        u_ifdm_sie_model.acc(1'b1, 12'h530, 8'h11);
        chk(grants === n, "grant off");
        usb_enable = 1;
        cacc(1'b1, 1'b1, 12'h523, 8'h77, 8'h00);
        u_ifdm_sie_model.acc(1'b0, 12'h523, 8'h00);
        chk(sie_rdata_ff === 8'h77 && grants === n + 1, "engine");
        fork
            cacc(1'b1, 1'b1, 12'h525, 8'h12, 8'h00);
            u_ifdm_sie_model.acc(1'b1, 12'h525, 8'h34);
        join
        cacc(1'b0, 1'b1, 12'h525, 8'h00, 8'h34);
        $display("usb done");
    endtask
    initial begin
        {clk, step_en, skip_flush, take_branch, usb_enable, core_req, core_we} = '0;
        {access_sel, full_addr_en, fetch_word, branch_offset, bank_pointer} = '0;
        {core_full_addr, core_addr_low, core_wdata, srst} = 29'h00000001;
        repeat (5) @(negedge clk);
        srst = 0;
        chk(program_counter_ff === 21'h000000, "pc reset");
        t_fetch;
        t_words;
        t_data;
        t_usb;
        stop_test;
    end
    initial begin
        #40000;
        chk(1'b0, "timeout");
        stop_test;
    end
endmodule
`default_nettype wire
